//--- rtl/rbc_reset_boot_ctrl.sv
`timescale 1ns/100ps
module rbc_reset_boot_ctrl #(
  parameter int         NSRC          = 4,
  parameter logic [7:0] RISE_MASK     = 8'h1F,
  parameter logic [7:0] FALL_MASK     = 8'h00,
  parameter logic [6:0] SLAVE_ADR_DEF = 7'h74
) (
  // clock and reset
  input  wire logic           sys_clk,
  input  wire logic           sys_rst,
  // device pins
  input  wire logic           deviceResetPinN,
  input  wire logic           testPin,
  input  wire logic [2:0]     bootConfigSelectPins,
  input  wire logic [1:0]     portSelectPins,
  output logic                gpioOut,
  output logic                gpioOe,
  output logic                directNvmMode,
  // register port from host interface
  input  rbc_pkg::rbc_req_t   regReq,
  output logic [7:0]          regRdData,
  output logic                regRdValid,
  // memory port
  output rbc_pkg::rbc_req_t   nvmReq,
  input  wire logic [7:0]     nvmRdData,
  // boot loader
  output logic                bootStart,
  output logic                bootFromNvm,
  output logic [2:0]          bootConfigSel,
  input  wire logic           bootLoadDone,
  output logic                bootCompleteFlag,
  // status sources
  input  wire logic [NSRC-1:0] statusSrc
);
  import rbc_pkg::*;

  typedef enum logic [1:0] {BT_IDLE, BT_WAIT, BT_LOAD, BT_DONE} rbc_boot_t;

  localparam int LW = NSRC + 1;

  logic              hardBit_reg, softBit_reg, afterHard_reg, testMode_reg;
  logic [1:0]        ifMode_reg;
  logic [6:0]        slaveAddr_reg;
  logic [2:0]        cfgSel_reg;
  logic              testSmp_reg;
  rbc_boot_t         boot_reg;
  logic [CNT_W-1:0]  dly_reg;
  logic              bankSel_reg;
  logic [LW-1:0]     latched_reg, prevEvt_reg;
  logic [7:0]        irqEn_reg, pinSrc_reg;
  logic [3:0]        pinCtrl_reg;
  logic [LW-1:0]     latched_next;

  ////////////////////////////////////////////////////////////////////////
  // reset scopes
  wire fullRst = sys_rst | ~deviceResetPinN;
  wire hardRst = fullRst | hardBit_reg;
  wire softRst = hardRst | softBit_reg;

  ////////////////////////////////////////////////////////////////////////
  // register decode
  function automatic logic hit(input rbc_req_t r, input logic [15:0] off,
                               input logic bank, input logic tm);
    hit = !tm && (r.addr == off) && (off == OFF_BANK_SEL || !bank);
  endfunction : hit

  wire nvmSel   = testMode_reg || (bankSel_reg && regReq.addr != OFF_BANK_SEL);
  wire rdBlock  = hardBit_reg;
  wire wrBank   = regReq.wr && hit(regReq, OFF_BANK_SEL, bankSel_reg, testMode_reg);
  wire wrMcr1   = regReq.wr && hit(regReq, OFF_MASTER_CONTROL_ONE, bankSel_reg, testMode_reg);
  wire wrLatch  = regReq.wr && hit(regReq, OFF_LATCHED, bankSel_reg, testMode_reg);
  wire wrIrqEn  = regReq.wr && hit(regReq, OFF_IRQ_EN, bankSel_reg, testMode_reg);
  wire wrPinC   = regReq.wr && hit(regReq, OFF_PIN_CTRL, bankSel_reg, testMode_reg);
  wire wrPinS   = regReq.wr && hit(regReq, OFF_PIN_SRC, bankSel_reg, testMode_reg);
  wire wrSlave  = regReq.wr && hit(regReq, OFF_SLAVE_ADDR, bankSel_reg, testMode_reg);

  ////////////////////////////////////////////////////////////////////////
  // status and interrupt summary
  wire [LW-1:0] evt    = {statusSrc, bootCompleteFlag};
  wire [LW-1:0] rise   = evt & ~prevEvt_reg;
  wire [LW-1:0] fall   = ~evt & prevEvt_reg;
  wire [LW-1:0] setv   = (rise & RISE_MASK[LW-1:0]) | (fall & FALL_MASK[LW-1:0]);
  wire [LW-1:0] clrv   = wrLatch ? regReq.wdata[LW-1:0] : '0;
  wire          irqSum = |(latched_reg & irqEn_reg[LW-1:0]);

  // set wins over a same-cycle clear so no edge is lost
  assign latched_next = (latched_reg & ~clrv) | setv;

  ////////////////////////////////////////////////////////////////////////
  // read mux; read-only fields have no write decode at all
  wire [7:0] regMux =
      (regReq.addr == OFF_BANK_SEL)   ? {7'h00, bankSel_reg} :
      (regReq.addr == OFF_MASTER_CONTROL_ONE)       ? {softBit_reg, hardBit_reg, 6'h00} :
      (regReq.addr == OFF_BOOT_STAT)  ? {1'b0, testSmp_reg, ifMode_reg, testMode_reg, cfgSel_reg} :
      (regReq.addr == OFF_LATCHED)    ? 8'(latched_reg) :
      (regReq.addr == OFF_IRQ_EN)     ? irqEn_reg :
      (regReq.addr == OFF_IRQ_STAT)   ? {7'h00, irqSum} :
      (regReq.addr == OFF_LIVE_STAT)  ? 8'(evt) :
      (regReq.addr == OFF_PIN_CTRL)   ? {4'h0, pinCtrl_reg} :
      (regReq.addr == OFF_PIN_SRC)    ? pinSrc_reg :
      (regReq.addr == OFF_SLAVE_ADDR) ? {1'b0, slaveAddr_reg} : 8'h00;
  wire [7:0] rdNext = rdBlock ? 8'h00 : (nvmSel ? nvmRdData : regMux);

  ////////////////////////////////////////////////////////////////////////
  // general-purpose pin
  wire pinSel = (pinSrc_reg == PIN_SRC_BOOT) ? bootCompleteFlag :
                (pinSrc_reg == PIN_SRC_IRQ)  ? irqSum : 1'b0;
  wire pinStat = pinCtrl_reg[3:2] == PIN_FN_STATUS;
  wire pinOutNext = pinStat ? (pinSel ^ pinCtrl_reg[0]) : (pinCtrl_reg == PIN_FN_HIGH);
  wire pinOeNext  = pinStat || pinCtrl_reg == PIN_FN_LOW || pinCtrl_reg == PIN_FN_HIGH;

  ////////////////////////////////////////////////////////////////////////
  // pin-release scope: only the reset pin or sys_rst touches these
  always_ff @(posedge sys_clk) begin
    if (fullRst) begin
      // pins are followed during reset, the value at release sticks
      ifMode_reg    <= portSelectPins;
      bootFromNvm   <= portSelectPins == PORT_SEL_NVM;
      testMode_reg  <= testPin && bootConfigSelectPins == 3'h0
                       && portSelectPins == PORT_SEL_NVM;
      hardBit_reg   <= 1'b0;
      afterHard_reg <= 1'b0;
      slaveAddr_reg <= SLAVE_ADR_DEF;
    end else begin
      if (wrMcr1) hardBit_reg <= regReq.wdata[MASTER_CONTROL_ONE_HARD_BIT];
      if (hardBit_reg) afterHard_reg <= 1'b1;
      if (wrSlave) slaveAddr_reg <= regReq.wdata[6:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // hard scope: config sampling, soft bit and boot controller
  always_ff @(posedge sys_clk) begin
    if (hardRst) begin
      cfgSel_reg       <= bootConfigSelectPins;
      testSmp_reg      <= testPin;
      softBit_reg      <= 1'b0;
      boot_reg         <= BT_IDLE;
      dly_reg          <= '0;
      bootStart        <= 1'b0;
      bootCompleteFlag <= 1'b0;
    end else begin
      if (wrMcr1) softBit_reg <= regReq.wdata[MASTER_CONTROL_ONE_SOFT_BIT];
      bootStart <= 1'b0;
      case (boot_reg)
        BT_IDLE: begin
          // after a hard clear the loader waits out the settle delay
          if (afterHard_reg) begin
            boot_reg <= BT_WAIT;
          end else begin
            boot_reg  <= BT_LOAD;
            bootStart <= 1'b1;
          end
        end
        BT_WAIT: begin
          dly_reg <= dly_reg + 1'b1;
          if (dly_reg == CNT_W'(HARD_DELAY_CYC - 1)) begin
            boot_reg  <= BT_LOAD;
            bootStart <= 1'b1;
          end
        end
        BT_LOAD: begin
          if (bootLoadDone) begin
            boot_reg         <= BT_DONE;
            bootCompleteFlag <= 1'b1;
          end
        end
        BT_DONE: boot_reg <= BT_DONE;
        default: boot_reg <= BT_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // soft scope: configuration and status
  always_ff @(posedge sys_clk) begin
    if (softRst) begin
      bankSel_reg <= BANK_SEL_RST;
      irqEn_reg   <= IRQ_EN_RST;
      pinCtrl_reg <= PIN_CTRL_RST;
      pinSrc_reg  <= PIN_SRC_RST;
      latched_reg <= '0;
      prevEvt_reg <= '0;
      gpioOut     <= 1'b0;
      gpioOe      <= 1'b0;
    end else begin
      if (wrBank)  bankSel_reg <= regReq.wdata[0];
      if (wrIrqEn) irqEn_reg   <= regReq.wdata;
      if (wrPinC)  pinCtrl_reg <= regReq.wdata[3:0];
      if (wrPinS)  pinSrc_reg  <= regReq.wdata;
      latched_reg <= latched_next;
      prevEvt_reg <= evt;
      gpioOut     <= pinOutNext;
      gpioOe      <= pinOeNext;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // host answers and memory port; always live, even in hard reset
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      regRdValid <= 1'b0;
      regRdData  <= 8'h00;
      nvmReq     <= '0;
    end else begin
      regRdValid   <= regReq.rd;
      regRdData    <= regReq.rd ? rdNext : 8'h00;
      nvmReq.rd    <= regReq.rd && nvmSel && !rdBlock;
      nvmReq.wr    <= regReq.wr && nvmSel;
      nvmReq.addr  <= regReq.addr;
      nvmReq.wdata <= regReq.wdata;
    end
  end

  // derived outputs, all from flops
  // boot source flop sits beside ifMode_reg; a hard clear never touches it
  assign bootConfigSel = cfgSel_reg;
  assign directNvmMode = testMode_reg;

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  a_pin_holds_default: assert property (
    !deviceResetPinN |=> !bankSel_reg && irqEn_reg == 8'h00 && !hardBit_reg)
    else $error("reset pin low did not hold defaults");

  a_pin_starts_boot: assert property (
    $rose(deviceResetPinN) |=> bootStart)
    else $error("boot not started after reset pin release");

  a_hard_delay_lo: assert property (disable iff (fullRst)
    $fell(hardBit_reg) |-> !bootStart [*8])
    else $error("boot started too early after hard clear");

  a_hard_delay_hi: assert property (disable iff (fullRst)
    $fell(hardBit_reg) |-> ##[25:75] bootStart)
    else $error("boot not started within delay after hard clear");

  a_hard_no_read: assert property (
    hardBit_reg && regReq.rd |=> regRdValid && regRdData == 8'h00)
    else $error("read answered during hard reset");

  a_hard_keeps_mode: assert property (disable iff (fullRst)
    hardBit_reg |=> $stable(ifMode_reg) && ($stable(slaveAddr_reg) || $past(wrSlave)))
    else $error("interface mode lost in hard reset");

  a_soft_no_boot: assert property (disable iff (fullRst)
    softBit_reg && !hardBit_reg |=> !bootStart)
    else $error("soft reset started boot");

  a_w1c_clear: assert property (disable iff (softRst)
    wrLatch && regReq.wdata[0] && !setv[0] |=> !latched_reg[0])
    else $error("write one did not clear latched bit");

  a_ro_ignored: assert property (disable iff (hardRst)
    regReq.wr && regReq.addr == OFF_BOOT_STAT |=> $stable(cfgSel_reg))
    else $error("read-only field changed by write");

  a_irq_pin: assert property (disable iff (softRst)
    pinStat && pinSrc_reg == PIN_SRC_IRQ && !pinCtrl_reg[0] |=> gpioOe && gpioOut == $past(irqSum))
    else $error("pin does not follow irq summary");

  a_bank_route: assert property (
    regReq.wr && bankSel_reg && regReq.addr != OFF_BANK_SEL |=> nvmReq.wr)
    else $error("bank select did not route to memory");

  a_test_block: assert property (disable iff (fullRst)
    testMode_reg && regReq.wr |=> $stable(bankSel_reg) && nvmReq.wr)
    else $error("register reached in direct memory mode");

  c_boot_done:  cover property (bootStart ##[1:20] bootCompleteFlag);
  c_hard_cycle: cover property ($fell(hardBit_reg) ##[25:75] bootStart);
  c_test_entry: cover property ($rose(testMode_reg));
  c_irq_pin:    cover property ($rose(gpioOut) && pinSrc_reg == PIN_SRC_IRQ);
endmodule : rbc_reset_boot_ctrl

//--- inc/rbc_pkg.sv
package rbc_pkg;
  // register offsets (byte index on the internal register port)
  localparam logic [15:0] OFF_BANK_SEL   = 16'h0000;
  localparam logic [15:0] OFF_MASTER_CONTROL_ONE       = 16'h0001;
  localparam logic [15:0] OFF_BOOT_STAT  = 16'h0002;
  localparam logic [15:0] OFF_LATCHED    = 16'h0003;
  localparam logic [15:0] OFF_IRQ_EN     = 16'h0004;
  localparam logic [15:0] OFF_IRQ_STAT   = 16'h0005;
  localparam logic [15:0] OFF_LIVE_STAT  = 16'h0006;
  localparam logic [15:0] OFF_PIN_CTRL   = 16'h0007;
  localparam logic [15:0] OFF_PIN_SRC    = 16'h0008;
  localparam logic [15:0] OFF_SLAVE_ADDR = 16'h0009;
  // field positions in master_control_one
  localparam int MASTER_CONTROL_ONE_SOFT_BIT = 7;
  localparam int MASTER_CONTROL_ONE_HARD_BIT = 6;
  // reset values
  localparam logic       BANK_SEL_RST = 1'b0;
  localparam logic [7:0] IRQ_EN_RST   = 8'h00;
  localparam logic [3:0] PIN_CTRL_RST = 4'h0;
  localparam logic [7:0] PIN_SRC_RST  = 8'h00;
  // pin function and output source codes
  localparam logic [1:0] PIN_FN_STATUS = 2'h1;
  localparam logic [3:0] PIN_FN_LOW    = 4'h2;
  localparam logic [3:0] PIN_FN_HIGH   = 4'h3;
  localparam logic [7:0] PIN_SRC_IRQ   = 8'h1E;
  localparam logic [7:0] PIN_SRC_BOOT  = 8'h1F;
  // port select value for external memory boot / test entry
  localparam logic [1:0] PORT_SEL_NVM  = 2'h3;
  // timing
  localparam int CLK_PERIOD_NS  = 40;
  localparam int HARD_DELAY_NS  = 2000;
  localparam int HARD_DELAY_CYC = (HARD_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 8;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } rbc_req_t;
endpackage : rbc_pkg

//--- testbench/rbc_boot_mem_model.sv
`timescale 1ns/100ps
module rbc_boot_mem_model #(
  parameter int LOAD_CYC = 12
) (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  // loader handshake
  input  wire logic        bootStart,
  output logic             bootLoadDone,
  // memory side
  input  rbc_pkg::rbc_req_t nvmReq,
  input  wire logic [15:0] rdAddr,
  output logic [7:0]       nvmRdData
);
  import rbc_pkg::*;
  logic [7:0] memArr [16];
  int         loadCnt;
  ////////////////////////////////////////////////////////////////////////////////
  // read is combinational: the design samples it in the request cycle
  assign nvmRdData = memArr[rdAddr[3:0]];
  always_ff @(posedge sys_clk) begin
    bootLoadDone <= 1'b0;
    if (sys_rst) begin
      loadCnt <= 0;
      for (int i = 0; i < 16; i++) begin
        memArr[i] <= 8'hA0 + 8'(i);
      end
    end else begin
      if (nvmReq.wr) begin
        memArr[nvmReq.addr[3:0]] <= nvmReq.wdata;
      end
      // a new start restarts the load, as a real loader would
      if (bootStart) begin
        loadCnt <= LOAD_CYC;
      end else if (loadCnt > 0) begin
        loadCnt      <= loadCnt - 1;
        bootLoadDone <= (loadCnt == 1);
      end
    end
  end
endmodule : rbc_boot_mem_model

//--- testbench/rbc_reset_boot_ctrl_test.sv
`timescale 1ns/100ps
module rbc_reset_boot_ctrl_test;
  import rbc_pkg::*;
  logic       sys_clk              = 1'b0;
  logic       sys_rst              = 1'b1;
  logic       deviceResetPinN      = 1'b0;
  logic       testPin              = 1'b0;
  logic [2:0] bootConfigSelectPins = 3'h5;
  logic [1:0] portSelectPins       = 2'h0;
  logic [3:0] statusSrc            = 4'h0;
  rbc_req_t   regReq               = '0;
  rbc_req_t   nvmReq;
  logic [7:0] regRdData, nvmRdData, rdVal;
  logic       regRdValid, gpioOut, gpioOe, directNvmMode, bootStart, bootFromNvm;
  logic       bootLoadDone, bootCompleteFlag;
  logic [2:0] bootConfigSel;
  int         miscompares = 0;
  int         checksDone  = 0;
  int         waitCnt, startCnt = 0, s0;
  always #20 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (bootStart === 1'b1) startCnt++;
  ////////////////////////////////////////////////////////////////////////////////
  rbc_reset_boot_ctrl i_rbc_reset_boot_ctrl (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .deviceResetPinN(deviceResetPinN), .testPin(testPin),
    .bootConfigSelectPins(bootConfigSelectPins), .portSelectPins(portSelectPins),
    .gpioOut(gpioOut), .gpioOe(gpioOe), .directNvmMode(directNvmMode), .regReq(regReq),
    .regRdData(regRdData), .regRdValid(regRdValid), .nvmReq(nvmReq),
    .nvmRdData(nvmRdData), .bootStart(bootStart), .bootFromNvm(bootFromNvm),
    .bootConfigSel(bootConfigSel), .bootLoadDone(bootLoadDone),
    .bootCompleteFlag(bootCompleteFlag), .statusSrc(statusSrc));
  rbc_boot_mem_model i_rbc_boot_mem_model (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .bootStart(bootStart), .bootLoadDone(bootLoadDone), .nvmReq(nvmReq),
    .rdAddr(regReq.addr), .nvmRdData(nvmRdData));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checksDone++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic regWr(input logic [15:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    regReq <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge sys_clk);
    regReq <= '0;
  endtask : regWr
  task automatic rdChk(input logic [15:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    regReq <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge sys_clk);
    regReq <= '0;
    #1;
    rdVal = regRdData;
    chk({7'h00, regRdValid}, 8'h01);
    chk(rdVal, e);
  endtask : rdChk
  // bounded wait, so a missing start cannot hang the run
  task automatic waitBoot(input int lim);
    waitCnt = 0;
    while (bootStart !== 1'b1 && waitCnt < lim) begin
      @(posedge sys_clk);
      #1;
      waitCnt++;
    end
  endtask : waitBoot
  task automatic pinReset(input logic t, input logic [2:0] c, input logic [1:0] p);
    @(posedge sys_clk);
    deviceResetPinN      <= 1'b0;
    testPin              <= t;
    bootConfigSelectPins <= c;
    portSelectPins       <= p;
    repeat (30) @(posedge sys_clk);
    deviceResetPinN <= 1'b1;
    waitBoot(4);
  endtask : pinReset
  task automatic testDone;
    $display("checks %0d mismatches %0d", checksDone, miscompares);
    if (miscompares == 0 && checksDone > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : testDone
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (40000) @(posedge sys_clk);
    miscompares++;
    testDone();
  end
  initial begin
    repeat (3) @(posedge sys_clk);
    sys_rst <= 1'b0;
    pinReset(1'b0, 3'h5, 2'h0);
    chk({7'h00, bootStart}, 8'h01);
    chk({bootFromNvm, 4'h0, bootConfigSel}, 8'h05);
    repeat (2500) @(posedge sys_clk);
    chk({7'h00, bootCompleteFlag}, 8'h01);
    rdChk(OFF_BOOT_STAT, 8'h05);
    rdChk(OFF_BANK_SEL, 8'h00);
    rdChk(OFF_SLAVE_ADDR, 8'h74);
    regWr(OFF_BOOT_STAT, 8'hFF);
    rdChk(OFF_BOOT_STAT, 8'h05);
    rdChk(16'h000A, 8'h00);
    rdChk(OFF_LATCHED, 8'h01);
    @(posedge sys_clk);
    statusSrc <= 4'h1;
    rdChk(OFF_LATCHED, 8'h03);
    rdChk(OFF_LIVE_STAT, 8'h03);
    rdChk(OFF_IRQ_STAT, 8'h00);
    regWr(OFF_IRQ_EN, 8'h02);
    rdChk(OFF_IRQ_STAT, 8'h01);
    regWr(OFF_PIN_CTRL, 8'h04);
    regWr(OFF_PIN_SRC, PIN_SRC_IRQ);
    repeat (3) @(posedge sys_clk);
    #1 chk({6'h00, gpioOe, gpioOut}, 8'h03);
    @(posedge sys_clk);
    statusSrc <= 4'h0;
    rdChk(OFF_LIVE_STAT, 8'h01);
    regWr(OFF_LATCHED, 8'h00);
    rdChk(OFF_LATCHED, 8'h03);
    regWr(OFF_LATCHED, 8'h02);
    rdChk(OFF_LATCHED, 8'h01);
    regWr(OFF_LATCHED, 8'h01);
    rdChk(OFF_LATCHED, 8'h00);
    repeat (3) @(posedge sys_clk);
    #1 chk({6'h00, gpioOe, gpioOut}, 8'h02);
    regWr(OFF_PIN_SRC, PIN_SRC_BOOT);
    repeat (3) @(posedge sys_clk);
    #1 chk({6'h00, gpioOe, gpioOut}, 8'h03);
    regWr(OFF_SLAVE_ADDR, 8'h15);
    s0 = startCnt;
    regWr(OFF_MASTER_CONTROL_ONE, 8'h80);
    regWr(OFF_MASTER_CONTROL_ONE, 8'h00);
    rdChk(OFF_PIN_SRC, 8'h00);
    rdChk(OFF_BOOT_STAT, 8'h05);
    rdChk(OFF_SLAVE_ADDR, 8'h15);
    chk(8'(startCnt - s0), 8'h00);
    regWr(OFF_IRQ_EN, 8'h02);
    testPin              <= 1'b1;
    bootConfigSelectPins <= 3'h3;
    portSelectPins       <= 2'h1;
    regWr(OFF_MASTER_CONTROL_ONE, 8'h40);
    rdChk(OFF_SLAVE_ADDR, 8'h00);
    regWr(OFF_MASTER_CONTROL_ONE, 8'h00);
    waitBoot(200);
    chk(8'(waitCnt >= 25 && waitCnt <= 75), 8'h01);
    chk({5'h00, bootConfigSel}, 8'h03);
    repeat (20) @(posedge sys_clk);
    rdChk(OFF_BOOT_STAT, 8'h43);
    rdChk(OFF_SLAVE_ADDR, 8'h15);
    rdChk(OFF_IRQ_EN, 8'h00);
    pinReset(1'b1, 3'h0, 2'h3);
    chk({6'h00, directNvmMode, bootFromNvm}, 8'h03);
    regWr(OFF_IRQ_EN, 8'h5A);
    #1 chk({nvmReq.wr, nvmReq.addr[6:0]}, 8'h84);
    rdChk(OFF_IRQ_EN, 8'h5A);
    pinReset(1'b0, 3'h5, 2'h0);
    chk({7'h00, directNvmMode}, 8'h00);
    regWr(OFF_BANK_SEL, 8'h01);
    regWr(OFF_PIN_CTRL, 8'h3C);
    rdChk(OFF_PIN_CTRL, 8'h3C);
    regWr(OFF_BANK_SEL, 8'h00);
    rdChk(OFF_PIN_CTRL, 8'h00);
    testDone();
  end
endmodule : rbc_reset_boot_ctrl_test
